// *** include/gsr_params.svh ***
// Constants for the bus status and service request block
`ifndef GSR_PARAMS_SVH
`define GSR_PARAMS_SVH
`define GSR_CMD_GTL 7'h01
`define GSR_CMD_SDC 7'h04
`define GSR_CMD_LLO 7'h11
`define GSR_CMD_DCL 7'h14
`define GSR_CMD_SPE 7'h18
`define GSR_CMD_SPD 7'h19
`define GSR_GRP_LISTEN 2'h1
`define GSR_GRP_TALK 2'h2
`define GSR_ADDR_UNIV 5'h1F
`define GSR_CHAR_CR 8'h0D
`define GSR_CHAR_LF 8'h0A
`define GSR_BIT_NEW 0
`define GSR_BIT_UNUSED 1
`define GSR_BIT_RANGE 2
`define GSR_BIT_ALARM 3
`define GSR_BIT_ERR 4
`define GSR_BIT_EVENT 5
`define GSR_BIT_RQS 6
`define GSR_BIT_LOG 7
`define GSR_REPORT_MASK 8'hBD
`define GSR_STB_RESET 8'h00
`define GSR_SRE_RESET 8'h00
`define GSR_PINS_IDLE 15'h7FFF
`endif

// *** include/gsr_pkg.sv ***
// Types for the bus status and service request block
package gsr_pkg;
  typedef enum logic [1:0] {
    GSR_TERM_CRLF = 2'h0,
    GSR_TERM_LFCR = 2'h1,
    GSR_TERM_LF   = 2'h2,
    GSR_TERM_EOI  = 2'h3
  } gsr_term_t;
  typedef enum logic [1:0] {
    GSR_AH_IDLE = 2'h0, GSR_AH_READY = 2'h1, GSR_AH_ACCEPT = 2'h3, GSR_AH_WAIT = 2'h2
  } gsr_ah_t;
  typedef enum logic [1:0] {
    GSR_SH_IDLE = 2'h0, GSR_SH_RFD = 2'h1, GSR_SH_DAV = 2'h3, GSR_SH_DONE = 2'h2
  } gsr_sh_t;
endpackage : gsr_pkg

// *** include/gsr_stat_if.sv ***
// Link between the bus logic and the status byte store
`timescale 1ns/1ps
interface gsr_stat_if;
  logic       new_reading;
  logic [3:0] range_flags;
  logic       alarm_active;
  logic       instrument_error;
  logic       esr_pending;
  logic       log_done;
  logic       sre_wr;
  logic [7:0] sre_wdata;
  logic       poll_done;
  logic [7:0] stb;
  logic [7:0] sre;
  logic       srq_req;
  modport core (input new_reading, range_flags, alarm_active, instrument_error, esr_pending,
                log_done, sre_wr, sre_wdata, poll_done, output stb, sre, srq_req);
  modport ctrl (output new_reading, range_flags, alarm_active, instrument_error, esr_pending,
                log_done, sre_wr, sre_wdata, poll_done, input stb, sre, srq_req);
endinterface : gsr_stat_if

// *** verilog/gsr_status_byte.sv ***
// Latched status byte, service request enable and request decision
`timescale 1ns/1ps
`include "gsr_params.svh"
module gsr_status_byte (
  input logic   clk,
  input logic   rst,
  gsr_stat_if.core st
);
  logic [7:0] rep;
  logic [7:0] set_bits;
  logic [7:0] sre;
  logic       srq_req;

  always_comb begin
    set_bits = '0;
    set_bits[`GSR_BIT_NEW]   = st.new_reading;
    set_bits[`GSR_BIT_RANGE] = |st.range_flags;
    set_bits[`GSR_BIT_ALARM] = st.alarm_active;
    set_bits[`GSR_BIT_ERR]   = st.instrument_error;
    set_bits[`GSR_BIT_EVENT] = st.esr_pending;
    set_bits[`GSR_BIT_LOG]   = st.log_done;
  end

  // A new event in the poll cycle survives the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      rep <= `GSR_STB_RESET;
    end else begin
      rep <= (set_bits | (st.poll_done ? '0 : rep)) & `GSR_REPORT_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sre <= `GSR_SRE_RESET;
    end else if (st.sre_wr) begin
      sre <= st.sre_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      srq_req <= 1'b0;
    end else begin
      srq_req <= sre[`GSR_BIT_RQS] && |(rep & sre & `GSR_REPORT_MASK);
    end
  end

  always_comb begin
    st.stb = rep;
    st.stb[`GSR_BIT_RQS] = srq_req;
  end
  assign st.sre     = sre;
  assign st.srq_req = srq_req;

  a_srq_gate: assert property (@(posedge clk) disable iff (rst)
    !sre[`GSR_BIT_RQS] |=> !srq_req) else $error("service request without enable");
  a_poll_clear: assert property (@(posedge clk) disable iff (rst)
    st.poll_done && set_bits == '0 |=> rep == '0) else $error("poll did not clear reports");
  a_latch_hold: assert property (@(posedge clk) disable iff (rst)
    !st.poll_done |=> (rep & $past(rep)) == $past(rep)) else $error("report bit lost");
  a_sre_load: assert property (@(posedge clk) disable iff (rst)
    st.sre_wr |=> sre == $past(st.sre_wdata)) else $error("enable register not loaded");
  a_bit1_zero: assert property (@(posedge clk) disable iff (rst)
    !rep[`GSR_BIT_UNUSED]) else $error("unused status bit set");
  a_range_set: assert property (@(posedge clk) disable iff (rst)
    |st.range_flags |=> rep[`GSR_BIT_RANGE]) else $error("overload not latched");
endmodule : gsr_status_byte

// *** verilog/gsr_top.sv ***
// Bus interface, remote state and serial poll of the instrument
//
// Functional notes
// - Four selectable receive terminators
// - Remote enable puts device in remote
// - Interface clear aborts any transfer
// - Local lockout blocks front panel
// - Device clear idles bus interface
// - Selective clear only when addressed listener
// - Go to local leaves remote
// - Addressed commands need prior listen address
// - Serial poll returns status; disable ends
// - Enabled set bit pulls request low
// - Request only with enable bit six
// - Serial poll clears latched report bits
// - Status query read changes nothing
// - Report bits latch until serial poll
// - Enable command loads enable register
// - Bit five reflects event status
// - Bit two on any range fault
// - Bit zero on new reading
// - Bit four on instrument error
// - Bit three on alarm condition
// - Bit seven when logging finishes
`timescale 1ns/1ps
`include "gsr_params.svh"
module gsr_top (
  input  logic               clk,
  input  logic               rst,
  input  logic [4:0]         my_addr,
  input  gsr_pkg::gsr_term_t term_sel,
  input  logic               atn_pin,
  input  logic               ren_pin,
  input  logic               ifc_pin,
  input  logic [7:0]         dio_in,
  output logic [7:0]         dio_out,
  output logic [7:0]         dio_oe_n,
  input  logic               eoi_in,
  output logic               eoi_out,
  output logic               eoi_oe_n,
  input  logic               dav_in,
  output logic               dav_out,
  output logic               dav_oe_n,
  input  logic               nrfd_in,
  output logic               nrfd_out,
  output logic               nrfd_oe_n,
  input  logic               ndac_in,
  output logic               ndac_out,
  output logic               ndac_oe_n,
  output logic               srq_out,
  output logic               srq_oe_n,
  output logic [7:0]         rx_byte,
  output logic               rx_valid,
  output logic               rx_end,
  input  logic [7:0]         tx_byte,
  input  logic               tx_last,
  input  logic               tx_valid,
  output logic               tx_ready,
  input  logic               sre_wr,
  input  logic [7:0]         sre_wdata,
  output logic [7:0]         sre_value,
  output logic [7:0]         stb_value,
  input  logic               new_reading,
  input  logic               sensor_over_range,
  input  logic               temperature_over_range,
  input  logic               sensor_under_range,
  input  logic               temperature_under_range,
  input  logic               alarm_active,
  input  logic               instrument_error,
  input  logic               esr_pending,
  input  logic               log_complete_flag,
  output logic               remote,
  output logic               panel_lock,
  output logic               dev_clear,
  output logic               listening,
  output logic               talking,
  output logic               spoll_active
);
  gsr_stat_if stat ();

  logic [14:0]      pin_meta;
  logic [14:0]      pin_sync;
  logic             atn_a;
  logic             ren_a;
  logic             ifc_a;
  logic             eoi_a;
  logic             dav_a;
  logic             nrfd_a;
  logic             ndac_a;
  logic [7:0]       bus_data;
  logic             addr_loaded;
  logic [4:0]       dev_addr;
  logic             ren_q;
  gsr_pkg::gsr_ah_t ah;
  gsr_pkg::gsr_ah_t next_ah;
  logic             ah_en;
  logic             take;
  logic [7:0]       byte_q;
  logic             cmd_q;
  logic             eoi_q;
  logic [6:0]       cmd7;
  logic             cmd_take;
  logic             dat_take;
  logic             dcl_hit;
  logic             term_hit;
  logic [7:0]       prev_rx;
  gsr_pkg::gsr_sh_t sh;
  gsr_pkg::gsr_sh_t next_sh;
  logic             sh_en;
  logic [7:0]       tx_q;
  logic [7:0]       next_tx;
  logic             last_q;
  logic             next_last;
  logic             poll_q;
  logic             next_poll;
  logic             sh_drive;

  function automatic logic addr_match(input logic [6:0] b, input logic [1:0] grp, input logic [4:0] a);
    return (b[6:5] == grp) && (b[4:0] == a);
  endfunction : addr_match

  function automatic logic term_end(input gsr_pkg::gsr_term_t sel, input logic [7:0] prv,
                                    input logic [7:0] cur, input logic eoi);
    case (sel)
      gsr_pkg::GSR_TERM_CRLF: term_end = (prv == `GSR_CHAR_CR) && (cur == `GSR_CHAR_LF);
      gsr_pkg::GSR_TERM_LFCR: term_end = (prv == `GSR_CHAR_LF) && (cur == `GSR_CHAR_CR);
      gsr_pkg::GSR_TERM_LF:   term_end = (cur == `GSR_CHAR_LF);
      default:                term_end = eoi;
    endcase
  endfunction : term_end

  // Bus lines are asynchronous to clk; all are low-true on the wire
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta <= `GSR_PINS_IDLE;
      pin_sync <= `GSR_PINS_IDLE;
    end else begin
      pin_meta <= {atn_pin, ren_pin, ifc_pin, eoi_in, dav_in, nrfd_in, ndac_in, dio_in};
      pin_sync <= pin_meta;
    end
  end

  assign atn_a    = ~pin_sync[14];
  assign ren_a    = ~pin_sync[13];
  assign ifc_a    = ~pin_sync[12];
  assign eoi_a    = ~pin_sync[11];
  assign dav_a    = ~pin_sync[10];
  assign nrfd_a   = ~pin_sync[9];
  assign ndac_a   = ~pin_sync[8];
  assign bus_data = ~pin_sync[7:0];

  // Address is read once after reset; a new address needs a fresh reset
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_loaded <= 1'b0;
      dev_addr    <= '0;
    end else if (!addr_loaded) begin
      addr_loaded <= 1'b1;
      dev_addr    <= my_addr;
    end
  end

  // Acceptor handshake
  assign ah_en = (atn_a | listening) & ~ifc_a;

  always_comb begin
    next_ah = ah;
    case (ah)
      gsr_pkg::GSR_AH_IDLE: begin
        if (ah_en) next_ah = gsr_pkg::GSR_AH_READY;
      end
      gsr_pkg::GSR_AH_READY: begin
        if (dav_a) next_ah = gsr_pkg::GSR_AH_ACCEPT;
      end
      gsr_pkg::GSR_AH_ACCEPT: begin
        if (!dav_a) next_ah = gsr_pkg::GSR_AH_WAIT;
      end
      gsr_pkg::GSR_AH_WAIT: begin
        next_ah = gsr_pkg::GSR_AH_IDLE;
      end
      default: begin
        next_ah = gsr_pkg::GSR_AH_IDLE;
      end
    endcase
    if (!ah_en || dcl_hit) next_ah = gsr_pkg::GSR_AH_IDLE;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ah        <= gsr_pkg::GSR_AH_IDLE;
      nrfd_oe_n <= 1'b1;
      ndac_oe_n <= 1'b1;
    end else begin
      ah        <= next_ah;
      nrfd_oe_n <= !(ah_en && next_ah != gsr_pkg::GSR_AH_READY);
      ndac_oe_n <= !(ah_en && next_ah != gsr_pkg::GSR_AH_ACCEPT);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      take   <= 1'b0;
      byte_q <= '0;
      cmd_q  <= 1'b0;
      eoi_q  <= 1'b0;
    end else begin
      take <= (ah == gsr_pkg::GSR_AH_READY) && dav_a && ah_en;
      if (ah == gsr_pkg::GSR_AH_READY && dav_a) begin
        byte_q <= bus_data;
        cmd_q  <= atn_a;
        eoi_q  <= eoi_a;
      end
    end
  end

  // Parity bit of a command byte is ignored
  assign cmd7     = byte_q[6:0];
  assign cmd_take = take && cmd_q && addr_loaded;
  assign dat_take = take && !cmd_q && listening;
  assign dcl_hit  = cmd_take && ((cmd7 == `GSR_CMD_DCL) ||
                                 (cmd7 == `GSR_CMD_SDC && listening));
  assign term_hit = term_end(term_sel, prev_rx, byte_q, eoi_q);

  // Listen and talk addressing
  always_ff @(posedge clk) begin
    if (rst || ifc_a) begin
      listening <= 1'b0;
      talking   <= 1'b0;
    end else if (cmd_take) begin
      if (addr_match(cmd7, `GSR_GRP_LISTEN, dev_addr)) begin
        listening <= 1'b1;
        talking   <= 1'b0;
      end else if (addr_match(cmd7, `GSR_GRP_LISTEN, `GSR_ADDR_UNIV)) begin
        listening <= 1'b0;
      end else if (addr_match(cmd7, `GSR_GRP_TALK, dev_addr)) begin
        talking   <= 1'b1;
        listening <= 1'b0;
      end else if (cmd7[6:5] == `GSR_GRP_TALK) begin
        talking <= 1'b0;
      end
    end
  end

  // Remote and lockout follow the remote enable line
  always_ff @(posedge clk) begin
    if (rst) begin
      ren_q      <= 1'b0;
      remote     <= 1'b0;
      panel_lock <= 1'b0;
    end else begin
      ren_q <= ren_a;
      if (!ren_a) begin
        remote     <= 1'b0;
        panel_lock <= 1'b0;
      end else begin
        if (!ren_q) begin
          remote <= 1'b1;
        end else if (cmd_take && cmd7 == `GSR_CMD_GTL && listening) begin
          remote <= 1'b0;
        end
        if (cmd_take && cmd7 == `GSR_CMD_LLO) begin
          panel_lock <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || ifc_a) begin
      spoll_active <= 1'b0;
    end else if (cmd_take && cmd7 == `GSR_CMD_SPE) begin
      spoll_active <= 1'b1;
    end else if (cmd_take && cmd7 == `GSR_CMD_SPD) begin
      spoll_active <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dev_clear <= 1'b0;
    end else begin
      dev_clear <= dcl_hit;
    end
  end

  // Received data and message end detection
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_byte  <= '0;
      rx_valid <= 1'b0;
      rx_end   <= 1'b0;
      prev_rx  <= '0;
    end else begin
      rx_valid <= dat_take;
      rx_end   <= dat_take && term_hit;
      if (dat_take) begin
        rx_byte <= byte_q;
        prev_rx <= term_hit ? '0 : byte_q;
      end
      if (dcl_hit || ifc_a) begin
        prev_rx <= '0;
      end
    end
  end

  // Source handshake: serial poll byte or user data
  assign sh_en    = talking && !atn_a && !ifc_a;
  assign sh_drive = (next_sh == gsr_pkg::GSR_SH_RFD) || (next_sh == gsr_pkg::GSR_SH_DAV);

  always_comb begin
    next_sh   = sh;
    next_tx   = tx_q;
    next_last = last_q;
    next_poll = poll_q;
    case (sh)
      gsr_pkg::GSR_SH_IDLE: begin
        if (sh_en && spoll_active) begin
          next_sh   = gsr_pkg::GSR_SH_RFD;
          next_tx   = stat.stb;
          next_last = 1'b0;
          next_poll = 1'b1;
        end else if (sh_en && tx_valid && tx_ready) begin
          next_sh   = gsr_pkg::GSR_SH_RFD;
          next_tx   = tx_byte;
          next_last = tx_last;
          next_poll = 1'b0;
        end
      end
      gsr_pkg::GSR_SH_RFD: begin
        if (!nrfd_a) next_sh = gsr_pkg::GSR_SH_DAV;
      end
      gsr_pkg::GSR_SH_DAV: begin
        if (!ndac_a) next_sh = gsr_pkg::GSR_SH_DONE;
      end
      gsr_pkg::GSR_SH_DONE: begin
        next_sh = gsr_pkg::GSR_SH_IDLE;
      end
      default: begin
        next_sh = gsr_pkg::GSR_SH_IDLE;
      end
    endcase
    if (!sh_en || dcl_hit) next_sh = gsr_pkg::GSR_SH_IDLE;
  end

  // Open-collector outputs: enable low pulls the line low, meaning true
  always_ff @(posedge clk) begin
    if (rst) begin
      sh             <= gsr_pkg::GSR_SH_IDLE;
      tx_q           <= '0;
      last_q         <= 1'b0;
      poll_q         <= 1'b0;
      tx_ready       <= 1'b0;
      stat.poll_done <= 1'b0;
      dio_oe_n       <= '1;
      dav_oe_n       <= 1'b1;
      eoi_oe_n       <= 1'b1;
    end else begin
      sh             <= next_sh;
      tx_q           <= next_tx;
      last_q         <= next_last;
      poll_q         <= next_poll;
      tx_ready       <= (next_sh == gsr_pkg::GSR_SH_IDLE) && sh_en && !spoll_active;
      stat.poll_done <= poll_q && (sh == gsr_pkg::GSR_SH_DAV) && (next_sh == gsr_pkg::GSR_SH_DONE);
      dio_oe_n       <= sh_drive ? ~next_tx : '1;
      dav_oe_n       <= !(next_sh == gsr_pkg::GSR_SH_DAV);
      eoi_oe_n       <= !(sh_drive && next_last);
    end
  end

  // Status byte store
  assign stat.new_reading      = new_reading;
  assign stat.range_flags      = {sensor_over_range, temperature_over_range,
                                  sensor_under_range, temperature_under_range};
  assign stat.alarm_active     = alarm_active;
  assign stat.instrument_error = instrument_error;
  assign stat.esr_pending      = esr_pending;
  assign stat.log_done         = log_complete_flag;
  assign stat.sre_wr           = sre_wr;
  assign stat.sre_wdata        = sre_wdata;

  gsr_status_byte u_status (
    .clk (clk),
    .rst (rst),
    .st  (stat.core)
  );

  // Query outputs are plain copies, so reading never clears anything
  always_ff @(posedge clk) begin
    if (rst) begin
      stb_value <= `GSR_STB_RESET;
      sre_value <= `GSR_SRE_RESET;
      srq_oe_n  <= 1'b1;
    end else begin
      stb_value <= stat.stb;
      sre_value <= stat.sre;
      srq_oe_n  <= !stat.srq_req;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dio_out  <= '0;
      eoi_out  <= 1'b0;
      dav_out  <= 1'b0;
      nrfd_out <= 1'b0;
      ndac_out <= 1'b0;
      srq_out  <= 1'b0;
    end else begin
      dio_out  <= '0;
      eoi_out  <= 1'b0;
      dav_out  <= 1'b0;
      nrfd_out <= 1'b0;
      ndac_out <= 1'b0;
      srq_out  <= 1'b0;
    end
  end

  a_term_lf: assert property (@(posedge clk) disable iff (rst)
    dat_take && term_sel == gsr_pkg::GSR_TERM_LF && byte_q == `GSR_CHAR_LF |=> rx_end && rx_valid)
    else $error("line feed terminator missed");
  a_ren_remote: assert property (@(posedge clk) disable iff (rst)
    ren_a && !ren_q |=> remote) else $error("remote not entered");
  a_ifc_abort: assert property (@(posedge clk) disable iff (rst)
    ifc_a |=> !listening && !talking && sh == gsr_pkg::GSR_SH_IDLE) else $error("transfer not aborted");
  a_llo_lock: assert property (@(posedge clk) disable iff (rst)
    cmd_take && cmd7 == `GSR_CMD_LLO && ren_a |=> panel_lock) else $error("lockout not applied");
  a_dcl_idle: assert property (@(posedge clk) disable iff (rst)
    dcl_hit |=> dev_clear && ah == gsr_pkg::GSR_AH_IDLE && sh == gsr_pkg::GSR_SH_IDLE)
    else $error("device clear left interface busy");
  a_sdc_gate: assert property (@(posedge clk) disable iff (rst)
    cmd_take && cmd7 == `GSR_CMD_SDC && !listening |=> !dev_clear) else $error("unaddressed clear acted");
  a_gtl_local: assert property (@(posedge clk) disable iff (rst)
    cmd_take && cmd7 == `GSR_CMD_GTL && listening && ren_q |=> !remote) else $error("go to local ignored");
  a_rx_addr: assert property (@(posedge clk) disable iff (rst)
    rx_valid |-> $past(listening)) else $error("data taken while unaddressed");
  a_poll_byte: assert property (@(posedge clk) disable iff (rst)
    sh == gsr_pkg::GSR_SH_IDLE && next_sh == gsr_pkg::GSR_SH_RFD && spoll_active
    |=> poll_q && tx_q == $past(stat.stb) && dio_oe_n == ~tx_q) else $error("poll byte wrong");
  a_srq_pin: assert property (@(posedge clk) disable iff (rst)
    stat.srq_req |=> !srq_oe_n) else $error("request line not pulled");
endmodule : gsr_top

// *** testbench/gsr_ctl_model.sv ***
// Bus controller model: sends command and data bytes, accepts talker bytes
`timescale 1ns/1ps
module gsr_ctl_model (
  input  wire logic       clk,
  input  wire logic [7:0] dio_w,
  input  wire logic       dav_w,
  input  wire logic       nrfd_w,
  input  wire logic       ndac_w,
  input  wire logic       eoi_w,
  output logic [7:0]      dio_n,
  output logic            dav_n,
  output logic            nrfd_n,
  output logic            ndac_n,
  output logic            atn_n,
  output logic            eoi_n
);
  initial begin
    {dio_n, dav_n, nrfd_n, ndac_n, atn_n, eoi_n} = '1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Waits are bounded: a dead device gives a wrong byte, not a hang
  task automatic send(input logic [7:0] b, input logic cmd, input logic last);
    atn_n = ~cmd;
    tick(4);
    // Released only after attention settles, so a held talker cannot finish a byte
    {nrfd_n, ndac_n} = 2'b11;
    for (int i = 0; i < 99 && !(nrfd_w === 1'b1 && ndac_w === 1'b0); i++) tick(1);
    dio_n = ~b;
    eoi_n = ~last;
    tick(1);
    dav_n = 1'b0;
    for (int i = 0; i < 99 && ndac_w !== 1'b1; i++) tick(1);
    {dav_n, dio_n, eoi_n} = '1;
    tick(1);
  endtask : send
  task automatic recv(output logic [7:0] b, output logic e);
    hold_ready();
    for (int i = 0; i < 99 && dav_w !== 1'b0; i++) tick(1);
    b = ~dio_w;
    e = ~eoi_w;
    ndac_n = 1'b1;
    for (int i = 0; i < 99 && dav_w !== 1'b1; i++) tick(1);
    // Not ready afterwards: the next byte waits until the bus is turned round
    {nrfd_n, ndac_n} = 2'b00;
  endtask : recv
  task automatic hold_ready();
    atn_n = 1'b1;
    {nrfd_n, ndac_n} = 2'b10;
  endtask : hold_ready
endmodule : gsr_ctl_model

// *** testbench/testbench.sv ***
// Self-checking bench for the bus status and service request block
`timescale 1ns/1ps
`include "gsr_params.svh"
module testbench;
  typedef struct {gsr_pkg::gsr_term_t t; logic [7:0] b0, b1; logic eoi; int ends;} gsr_trow_t;
  typedef struct {logic [8:0] ev; logic [7:0] sre, stb;} gsr_srow_t;
  localparam logic [4:0] ADDR = 5'h05;
  localparam logic [6:0] LSN = {`GSR_GRP_LISTEN, ADDR};
  localparam logic [6:0] TLK = {`GSR_GRP_TALK, ADDR};
  localparam logic [6:0] UNL = 7'h3F;
  logic clk, rst, ren_n, ifc_n, tx_last, tx_valid, sre_wr, eoi_oe_n, dav_oe_n, nrfd_oe_n, ndac_oe_n;
  logic srq_oe_n, rx_valid, rx_end, tx_ready, remote, panel_lock, dev_clear, listening, talking;
  logic spoll_active, c_dav, c_nrfd, c_ndac, c_atn, c_eoi;
  logic [7:0] tx_byte, sre_wdata, dio_oe_n, rx_byte, sre_value, stb_value, c_dio, rx_last;
  logic [8:0] ev;
  gsr_pkg::gsr_term_t term_sel;
  logic [7:0] dio_out;
  logic [4:0] ln_out;
  int failures, checked, dc_cnt = 0, end_cnt = 0;
  // Pull-ups: a line is low only where some party pulls it
  wire [7:0] dio_w = c_dio & (dio_oe_n | {8{rst}});
  wire dav_w = c_dav & (dav_oe_n | rst);
  wire nrfd_w = c_nrfd & (nrfd_oe_n | rst);
  wire ndac_w = c_ndac & (ndac_oe_n | rst);
  wire eoi_w = c_eoi & (eoi_oe_n | rst);
  gsr_trow_t trows[5] = '{'{gsr_pkg::GSR_TERM_CRLF, 8'h0D, 8'h0A, 1'b0, 1},
    '{gsr_pkg::GSR_TERM_LFCR, 8'h0A, 8'h0D, 1'b0, 2}, '{gsr_pkg::GSR_TERM_LF, 8'h41, 8'h0A, 1'b0, 3},
    '{gsr_pkg::GSR_TERM_EOI, 8'h41, 8'h42, 1'b1, 4}, '{gsr_pkg::GSR_TERM_LF, 8'h0D, 8'h41, 1'b0, 4}};
  gsr_srow_t srows[9] = '{'{9'h001, 8'hFF, 8'h41}, '{9'h002, 8'hFF, 8'h44}, '{9'h004, 8'h04, 8'h04},
    '{9'h008, 8'h44, 8'h44}, '{9'h010, 8'hFF, 8'h44}, '{9'h020, 8'h48, 8'h48}, '{9'h040, 8'h40, 8'h10},
    '{9'h080, 8'hFF, 8'h60}, '{9'h100, 8'hFF, 8'hC0}};
  gsr_top dut_u (.clk, .rst, .my_addr(ADDR), .term_sel, .atn_pin(c_atn), .ren_pin(ren_n), .ifc_pin(ifc_n),
    .dio_in(dio_w), .dio_out, .dio_oe_n, .eoi_in(eoi_w), .eoi_out(ln_out[0]), .eoi_oe_n, .dav_in(dav_w),
    .dav_out(ln_out[1]), .dav_oe_n, .nrfd_in(nrfd_w), .nrfd_out(ln_out[2]), .nrfd_oe_n, .ndac_in(ndac_w),
    .ndac_out(ln_out[3]), .ndac_oe_n, .srq_out(ln_out[4]), .srq_oe_n, .rx_byte, .rx_valid, .rx_end, .tx_byte,
    .tx_last, .tx_valid,
    .tx_ready, .sre_wr, .sre_wdata, .sre_value, .stb_value, .new_reading(ev[0]), .sensor_over_range(ev[1]),
    .temperature_over_range(ev[2]), .sensor_under_range(ev[3]), .temperature_under_range(ev[4]),
    .alarm_active(ev[5]), .instrument_error(ev[6]), .esr_pending(ev[7]), .log_complete_flag(ev[8]),
    .remote, .panel_lock, .dev_clear, .listening, .talking, .spoll_active);
  gsr_ctl_model ctl_u (.clk, .dio_w, .dav_w, .nrfd_w, .ndac_w, .eoi_w, .dio_n(c_dio), .dav_n(c_dav),
    .nrfd_n(c_nrfd), .ndac_n(c_ndac), .atn_n(c_atn), .eoi_n(c_eoi));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (dev_clear === 1'b1) dc_cnt <= dc_cnt + 1;
    if (rx_valid === 1'b1) rx_last <= rx_byte;
    if (rx_valid === 1'b1 && rx_end === 1'b1) end_cnt <= end_cnt + 1;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic cmd(input logic [6:0] c);
    ctl_u.send({1'b0, c}, 1'b1, 1'b0);
    tick(2);
  endtask : cmd
  task automatic spoll(output logic [7:0] b);
    logic e;
    cmd(`GSR_CMD_SPE);
    cmd(TLK);
    ctl_u.recv(b, e);
    cmd(`GSR_CMD_SPD);
  endtask : spoll
  task automatic wrap_up();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    logic [7:0] b;
    {rst, ren_n, ifc_n} = 3'b111;
    {tx_valid, tx_last, sre_wr, ev, tx_byte, sre_wdata, failures, checked} = '0;
    term_sel = gsr_pkg::GSR_TERM_CRLF;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    tick(4);
    chk(stb_value, `GSR_STB_RESET, "stb reset");
    chk(sre_value, `GSR_SRE_RESET, "sre reset");
    chk({remote, panel_lock, listening, talking, spoll_active, srq_oe_n, dav_oe_n, nrfd_oe_n}, 8'h07, "idle");
    ren_n = 1'b0;
    tick(6);
    chk({7'h0, remote}, 8'h01, "remote");
    cmd(`GSR_CMD_LLO);
    chk({7'h0, panel_lock}, 8'h01, "lockout");
    cmd(UNL);
    cmd(`GSR_CMD_GTL);
    chk({7'h0, remote}, 8'h01, "gtl unaddressed");
    cmd(`GSR_CMD_SDC);
    chk(8'(dc_cnt), 8'h00, "sdc unaddressed");
    cmd(LSN);
    cmd(`GSR_CMD_GTL);
    chk({listening, remote}, 8'h02, "gtl");
    cmd(`GSR_CMD_SDC);
    chk(8'(dc_cnt), 8'h01, "sdc");
    cmd(`GSR_CMD_DCL);
    chk(8'(dc_cnt), 8'h02, "dcl");
    chk({dio_oe_n[6:0], dav_oe_n}, 8'hFF, "dcl idle");
    foreach (trows[i]) begin
      term_sel = trows[i].t;
      ctl_u.send(trows[i].b0, 1'b0, 1'b0);
      ctl_u.send(trows[i].b1, 1'b0, trows[i].eoi);
      tick(4);
      chk(rx_last, trows[i].b1, "rx byte");
      chk(8'(end_cnt), 8'(trows[i].ends), "terminator");
    end
    foreach (srows[i]) begin
      sre_wdata = srows[i].sre;
      sre_wr = 1'b1;
      tick(1);
      sre_wr = 1'b0;
      tick(2);
      chk(sre_value, srows[i].sre, "enable");
      ev = srows[i].ev;
      tick(1);
      ev = '0;
      tick(12);
      chk(stb_value, srows[i].stb, "status");
      chk({7'h0, srq_oe_n}, {7'h0, ~srows[i].stb[6]}, "srq line");
      chk(stb_value, srows[i].stb, "stb reread");
      spoll(b);
      chk(b, srows[i].stb, "poll byte");
      tick(4);
      chk({stb_value[7:1], spoll_active}, 8'h00, "poll clear");
      chk({7'h0, srq_oe_n}, 8'h01, "srq off");
    end
    ctl_u.hold_ready();
    tick(6);
    chk({7'h0, tx_ready}, 8'h01, "talker ready");
    tx_byte = 8'h5A;
    tx_last = 1'b1;
    tx_valid = 1'b1;
    tick(14);
    chk({talking, dav_w, eoi_w, tx_ready}, 8'h08, "talker busy");
    chk(~dio_w, 8'h5A, "talker byte");
    ifc_n = 1'b0;
    tick(6);
    chk({dio_w[6:0], dav_w}, 8'hFF, "ifc released");
    chk({listening, talking, spoll_active}, 8'h00, "ifc state");
    chk(dio_out | {3'h0, ln_out}, 8'h00, "pin levels");
    ifc_n = 1'b1;
    tx_valid = 1'b0;
    tx_last = 1'b0;
    tick(4);
    wrap_up();
  end
  // Whole run is about a thousand cycles; twenty thousand means a hang
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
endmodule : testbench
